// ### include/fault_pkg.sv
package fault_pkg;

  // ****************************************
  // Object dictionary map
  // ****************************************
  localparam logic [15:0] IDX_FAULT_SUMMARY = 16'h1001;
  localparam logic [15:0] IDX_FAULT_HISTORY = 16'h1003;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FIRST_ENTRY = 8'h01;
  localparam logic [7:0] SUB_LAST_ENTRY = 8'h08;
  localparam int HIST_DEPTH = 8;
  localparam logic [7:0] COUNT_MAX = 8'h08;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] SUMMARY_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [31:0] ENTRY_RESET = 32'h00000000;

  // ****************************************
  // Summary bit positions
  // ****************************************
  localparam int BIT_ANY = 0;
  localparam int BIT_CURRENT = 1;
  localparam int BIT_SUPPLY = 2;
  localparam int BIT_TEMP = 3;
  localparam int BIT_LINK = 4;
  localparam int BIT_PROFILE = 5;
  localparam int BIT_SPARE = 6;
  localparam int BIT_VENDOR = 7;

  // ****************************************
  // Abort codes
  // ****************************************
  localparam logic [31:0] ABORT_EMPTY_HISTORY = 32'h08000024;
  localparam logic [31:0] ABORT_NO_OBJECT = 32'h00000001;
  localparam logic [31:0] ABORT_READ_ONLY = 32'h00000002;
  localparam logic [31:0] ABORT_BAD_VALUE = 32'h00000003;

  // ****************************************
  // Fault numbers
  // ****************************************
  localparam logic [7:0] FN_WATCHDOG = 8'h00;
  localparam logic [7:0] FN_SUPPLY_HIGH = 8'h01;
  localparam logic [7:0] FN_CURRENT_HIGH = 8'h02;
  localparam logic [7:0] FN_SUPPLY_LOW = 8'h03;
  localparam logic [7:0] FN_FIELDBUS = 8'h04;
  localparam logic [7:0] FN_GUARD_SLOW = 8'h06;
  localparam logic [7:0] FN_SENSOR1 = 8'h07;
  localparam logic [7:0] FN_SENSOR2 = 8'h08;
  localparam logic [7:0] FN_SENSOR3 = 8'h09;
  localparam logic [7:0] FN_LIMIT_POS = 8'h0a;
  localparam logic [7:0] FN_LIMIT_NEG = 8'h0b;
  localparam logic [7:0] FN_OVERTEMP = 8'h0c;
  localparam logic [7:0] FN_FOLLOWING = 8'h0d;
  localparam logic [7:0] FN_STORE_FULL = 8'h0e;
  localparam logic [7:0] FN_BLOCKED = 8'h0f;
  localparam logic [7:0] FN_STORE_DAMAGED = 8'h10;
  localparam logic [7:0] FN_PDO_SLOW = 8'h11;
  localparam logic [7:0] FN_SENSOR_N = 8'h12;
  localparam logic [7:0] FN_PDO_LEN_ERR = 8'h13;
  localparam logic [7:0] FN_PDO_LEN_OVER = 8'h14;
  localparam logic [7:0] FN_RESTART_WARN = 8'h15;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic vendor;
    logic profile;
    logic link;
    logic temp;
    logic supply;
    logic current;
  } fault_cat_t;

  typedef struct packed {
    logic [7:0] number;
    logic [15:0] code;
  } fault_report_t;

  typedef struct packed {
    logic [7:0] number;
    logic [7:0] fclass;
    logic [15:0] code;
  } hist_entry_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] index;
    logic [7:0] subindex;
    logic [31:0] wdata;
  } od_req_t;

  typedef struct packed {
    logic ack;
    logic abort;
    logic [31:0] abort_code;
    logic [31:0] rdata;
  } od_rsp_t;

endpackage

// ### rtl/fault_register_bank.sv
`timescale 1ns/1ps
// Summary of operation
// - Summary bit of a fault's category is set while that fault is present.
// - Category bits clear by themselves once the fault has gone away.
// - Bit 0 is set whenever any fault of any category is present.
// - Bits 1..5 current, supply, temp, link, profile; 7 vendor; 6 reads zero.
// - Every reported fault also records a 32-bit descriptor in the history.
// - History holds up to eight descriptors in slots 1..8 behind count slot 0.
// - New descriptor goes to slot 1, older ones move back, oldest dropped.
// - Slots 1..7 each move back exactly one position on every push that does not coincide with a clear.
// - Slot 0 is an 8-bit read/write fault count, reset value zero.
// - Reading slots 1..8 with an empty history aborts with 08000024h.
// - Writing zero to slot 0 restarts counting and empties the history.
// - Entry packs number in 31..24, class in 23..16, code in 15..0.
// - Numbers 0..4: watchdog, supply high, current high, supply low, fieldbus.
// - Numbers 6, 17, 19, 20: guarding slow, PDO slow, PDO length faults.
// - Numbers 7, 8, 9 are sensors one to three; 18 any further sensor.
// - Numbers 10, 11 limits, 12 overtemperature, 13 following, 15 blocked.
// - Numbers 14, 16, 21 are nonvolatile store full, damaged, restart warning.
// - Class byte of an entry equals the summary value when it is recorded.
module fault_register_bank
  import fault_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire fault_cat_t fault_cat,
  input wire logic fault_push,
  input wire fault_report_t fault_report,
  input wire od_req_t od_req,
  output od_rsp_t od_rsp,
  output logic [7:0] fault_summary,
  output logic [7:0] fault_count,
  output logic unknown_number
);

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic is_entry_sub(input logic [7:0] sub);
    is_entry_sub = (sub >= SUB_FIRST_ENTRY) && (sub <= SUB_LAST_ENTRY);
  endfunction

  function automatic logic number_known(input logic [7:0] n);
    number_known = 1'b0;
    unique case (n)
      FN_WATCHDOG, FN_SUPPLY_HIGH, FN_CURRENT_HIGH, FN_SUPPLY_LOW, FN_FIELDBUS: begin
        number_known = 1'b1;
      end
      FN_GUARD_SLOW, FN_PDO_SLOW, FN_PDO_LEN_ERR, FN_PDO_LEN_OVER: begin
        number_known = 1'b1;
      end
      FN_SENSOR1, FN_SENSOR2, FN_SENSOR3, FN_SENSOR_N: begin
        number_known = 1'b1;
      end
      FN_LIMIT_POS, FN_LIMIT_NEG, FN_OVERTEMP, FN_FOLLOWING, FN_BLOCKED: begin
        number_known = 1'b1;
      end
      FN_STORE_FULL, FN_STORE_DAMAGED, FN_RESTART_WARN: begin
        number_known = 1'b1;
      end
      default: begin
        number_known = 1'b0;
      end
    endcase
  endfunction

  // ****************************************
  // Fault summary
  // ****************************************
  logic [7:0] summary_r;
  logic [7:0] summary_nxt;
  logic any_fault_flag;

  // Category bits follow the live fault levels, so they drop on their own
  assign any_fault_flag = |fault_cat;
  always_comb begin
    summary_nxt = SUMMARY_RESET;
    summary_nxt[BIT_ANY] = any_fault_flag;
    summary_nxt[BIT_CURRENT] = fault_cat.current;
    summary_nxt[BIT_SUPPLY] = fault_cat.supply;
    summary_nxt[BIT_TEMP] = fault_cat.temp;
    summary_nxt[BIT_LINK] = fault_cat.link;
    summary_nxt[BIT_PROFILE] = fault_cat.profile;
    summary_nxt[BIT_SPARE] = 1'b0;
    summary_nxt[BIT_VENDOR] = fault_cat.vendor;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      summary_r <= SUMMARY_RESET;
    end else begin
      summary_r <= summary_nxt;
    end
  end

  // ****************************************
  // Request decode
  // ****************************************
  wire hit_summary = od_req.index == IDX_FAULT_SUMMARY;
  wire hit_history = od_req.index == IDX_FAULT_HISTORY;
  wire sub_is_count = od_req.subindex == SUB_COUNT;
  wire sub_is_entry = is_entry_sub(od_req.subindex);
  wire rd_summary = od_req.valid && !od_req.write && hit_summary && sub_is_count;
  wire rd_count = od_req.valid && !od_req.write && hit_history && sub_is_count;
  wire rd_entry = od_req.valid && !od_req.write && hit_history && sub_is_entry;
  wire wr_count = od_req.valid && od_req.write && hit_history && sub_is_count;
  wire wr_ro = od_req.valid && od_req.write && ((hit_summary && sub_is_count) || (hit_history && sub_is_entry));
  wire known_obj = (hit_summary && sub_is_count) || (hit_history && (sub_is_count || sub_is_entry));
  wire no_obj = od_req.valid && !known_obj;
  wire clear_hist = wr_count && (od_req.wdata == 32'h00000000);
  wire bad_value = wr_count && (od_req.wdata != 32'h00000000);

  // ****************************************
  // History stack
  // ****************************************
  logic [31:0] entry_r [HIST_DEPTH];
  logic [31:0] entry_nxt [HIST_DEPTH];
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  hist_entry_t new_entry;

  assign new_entry.number = fault_report.number;
  // Live summary so the new fault's own category shows in its class byte
  assign new_entry.fclass = summary_nxt;
  assign new_entry.code = fault_report.code;

  // Push wins over a simultaneous clear: the new fault survives in slot 1
  assign entry_nxt[0] = fault_push ? new_entry : (clear_hist ? ENTRY_RESET : entry_r[0]);

  genvar gi;
  generate
    for (gi = 1; gi < HIST_DEPTH; gi++) begin : g_shift
      assign entry_nxt[gi] = clear_hist ? ENTRY_RESET : (fault_push ? entry_r[gi-1] : entry_r[gi]);
    end
  endgenerate

  generate
    for (gi = 0; gi < HIST_DEPTH; gi++) begin : g_store
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          entry_r[gi] <= ENTRY_RESET;
        end else begin
          entry_r[gi] <= entry_nxt[gi];
        end
      end
    end
  endgenerate

  wire [7:0] count_base = clear_hist ? COUNT_RESET : count_r;
  wire count_full = count_base >= COUNT_MAX;
  assign count_nxt = (fault_push && !count_full) ? count_base + 8'h01 : count_base;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= COUNT_RESET;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ****************************************
  // Response
  // ****************************************
  wire [2:0] slot_sel = od_req.subindex[2:0] - 3'h1;
  wire empty_read = rd_entry && (count_r == COUNT_RESET);
  wire [31:0] rdata_sel = rd_summary ? {24'h000000, summary_r} :
                          rd_count ? {24'h000000, count_r} :
                          (rd_entry && !empty_read) ? entry_r[slot_sel] : 32'h00000000;
  wire abort_sel = no_obj || wr_ro || bad_value || empty_read;
  wire [31:0] code_sel = no_obj ? ABORT_NO_OBJECT :
                         wr_ro ? ABORT_READ_ONLY :
                         bad_value ? ABORT_BAD_VALUE :
                         empty_read ? ABORT_EMPTY_HISTORY : 32'h00000000;

  od_rsp_t rsp_r;
  od_rsp_t rsp_nxt;
  logic unknown_r;

  always_comb begin
    rsp_nxt.ack = od_req.valid;
    rsp_nxt.abort = abort_sel;
    rsp_nxt.abort_code = code_sel;
    rsp_nxt.rdata = rdata_sel;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rsp_r <= '0;
      unknown_r <= 1'b0;
    end else begin
      rsp_r <= rsp_nxt;
      unknown_r <= fault_push && !number_known(fault_report.number);
    end
  end

  assign od_rsp = rsp_r;
  assign fault_summary = summary_r;
  assign fault_count = count_r;
  assign unknown_number = unknown_r;

endmodule

// ### tb/error_register_and_error_history_tb.sv
`timescale 1ns/1ps
module error_register_and_error_history_tb import fault_pkg::*;;
  // ****************************************
  // Bench
  // ****************************************
  typedef struct packed {fault_cat_t cat; logic [7:0] sum;} row_t;
  logic ref_clk, nrst, fault_push, unknown_number;
  fault_cat_t fault_cat;
  fault_report_t fault_report;
  od_req_t od_req;
  od_rsp_t od_rsp, rsp;
  logic [7:0] fault_summary, fault_count;
  int err_count, comparisons;
  row_t rows [7] = '{'{6'h01, 8'h03}, '{6'h02, 8'h05}, '{6'h04, 8'h09}, '{6'h08, 8'h11}, '{6'h10, 8'h21},
    '{6'h20, 8'h81}, '{6'h3f, 8'hbf}};
  fault_register_bank dut (.ref_clk(ref_clk), .nrst(nrst), .fault_cat(fault_cat), .fault_push(fault_push),
    .fault_report(fault_report), .od_req(od_req), .od_rsp(od_rsp), .fault_summary(fault_summary),
    .fault_count(fault_count), .unknown_number(unknown_number));
  od_master mst (.ref_clk(ref_clk), .od_req(od_req), .od_rsp(od_rsp));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rsp(input od_rsp_t r, input logic ab, input logic [31:0] v);
    chk({r.ack, r.abort, ab ? r.abort_code : r.rdata}, {1'b1, ab, v});
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] s);
    mst.xfer(1'b0, i, s, 32'h0, rsp);
  endtask
  task automatic push(input logic [7:0] n, input fault_cat_t c);
    // Start on a fresh edge so back-to-back pushes never glitch the strobe
    @(negedge ref_clk);
    fault_cat = c;
    fault_report = '{number: n, code: {8'h70, n}};
    fault_push = 1'b1;
    @(negedge ref_clk);
    fault_push = 1'b0;
  endtask
  task automatic stop_test;
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    err_count = 0;
    comparisons = 0;
    nrst = 1'b0;
    fault_push = 1'b0;
    fault_cat = '0;
    fault_report = '0;
    repeat (20) @(negedge ref_clk);
    chk(34'({fault_summary, fault_count}), 34'h0);
    nrst = 1'b1;
    rd(IDX_FAULT_HISTORY, 8'h03);
    chk_rsp(rsp, 1'b1, ABORT_EMPTY_HISTORY);
    rd(16'h1002, 8'h00);
    chk_rsp(rsp, 1'b1, ABORT_NO_OBJECT);
    for (int n = 0; n < 23; n++) begin
      push(8'(n), '0);
      chk(34'(unknown_number), 34'(n == 5 || n == 22));
      chk(34'(fault_count), 34'(n < 8 ? n + 1 : 8));
    end
    for (int k = 1; k <= 8; k++) begin
      rd(IDX_FAULT_HISTORY, 8'(k));
      chk_rsp(rsp, 1'b0, {8'(23 - k), 8'h00, 8'h70, 8'(23 - k)});
    end
    mst.xfer(1'b1, IDX_FAULT_SUMMARY, 8'h00, 32'hff, rsp);
    chk_rsp(rsp, 1'b1, ABORT_READ_ONLY);
    mst.xfer(1'b1, IDX_FAULT_HISTORY, SUB_COUNT, 32'h0, rsp);
    chk_rsp(rsp, 1'b0, 32'h0);
    chk(34'(fault_count), 34'h0);
    rd(IDX_FAULT_HISTORY, SUB_LAST_ENTRY);
    chk_rsp(rsp, 1'b1, ABORT_EMPTY_HISTORY);
    foreach (rows[i]) begin
      push(8'(i), rows[i].cat);
      chk(34'(fault_summary), 34'(rows[i].sum));
      rd(IDX_FAULT_HISTORY, SUB_FIRST_ENTRY);
      chk_rsp(rsp, 1'b0, {8'(i), rows[i].sum, 8'h70, 8'(i)});
    end
    rd(IDX_FAULT_SUMMARY, SUB_COUNT);
    chk_rsp(rsp, 1'b0, 32'hbf);
    fault_cat = '0;
    @(negedge ref_clk);
    chk(34'(fault_summary), 34'h0);
    rd(IDX_FAULT_HISTORY, SUB_COUNT);
    chk_rsp(rsp, 1'b0, 32'h7);
    mst.xfer(1'b1, IDX_FAULT_HISTORY, SUB_COUNT, 32'h5, rsp);
    chk_rsp(rsp, 1'b1, ABORT_BAD_VALUE);
    chk(34'(fault_count), 34'h7);
    mst.xfer(1'b1, IDX_FAULT_HISTORY, SUB_FIRST_ENTRY, 32'h1, rsp);
    chk_rsp(rsp, 1'b1, ABORT_READ_ONLY);
    // Push and clear in one cycle: the new fault must survive alone
    fork
      push(FN_BLOCKED, 6'h01);
      mst.xfer(1'b1, IDX_FAULT_HISTORY, SUB_COUNT, 32'h0, rsp);
    join
    chk_rsp(rsp, 1'b0, 32'h0);
    chk(34'(fault_count), 34'h1);
    rd(IDX_FAULT_HISTORY, SUB_FIRST_ENTRY);
    chk_rsp(rsp, 1'b0, {FN_BLOCKED, 8'h03, 8'h70, FN_BLOCKED});
    rd(IDX_FAULT_HISTORY, 8'h02);
    chk_rsp(rsp, 1'b0, 32'h0);
    nrst = 1'b0;
    @(negedge ref_clk);
    chk(34'({fault_summary, fault_count}), 34'h0);
    nrst = 1'b1;
    rd(IDX_FAULT_HISTORY, SUB_FIRST_ENTRY);
    chk_rsp(rsp, 1'b1, ABORT_EMPTY_HISTORY);
    chk(34'(fault_summary), 34'h03);
    stop_test();
  end
  // Run needs under 150 cycles; this margin only catches a hang
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
endmodule

// ### tb/fault_monitor.sv
`timescale 1ns/1ps
module fault_monitor
  import fault_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire fault_cat_t fault_cat,
  input wire logic fault_push,
  input wire fault_report_t fault_report,
  input wire od_req_t od_req,
  input wire od_rsp_t od_rsp,
  input wire logic [7:0] fault_summary,
  input wire logic [7:0] fault_count,
  input wire logic unknown_number
);
  // ****************************************
  // Port checks
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire hist = od_req.valid && od_req.index == IDX_FAULT_HISTORY;
  wire rd_cnt = hist && !od_req.write && od_req.subindex == SUB_COUNT;
  wire clr = hist && od_req.write && od_req.subindex == SUB_COUNT && od_req.wdata == 32'h0;
  wire rd_ent = hist && !od_req.write && od_req.subindex >= SUB_FIRST_ENTRY && od_req.subindex <= SUB_LAST_ENTRY;
  sequence s_ok; od_rsp.ack && !od_rsp.abort; endsequence
  property p_cat; $past(nrst) |-> fault_summary[7:1] == {$past(fault_cat.vendor), 1'b0, $past(fault_cat[4:0])}; endproperty
  property p_any; fault_summary[0] == |fault_summary[7:1]; endproperty
  property p_max; fault_count <= COUNT_MAX; endproperty
  property p_push; fault_push && !clr |=> fault_count == (($past(fault_count) == COUNT_MAX) ? COUNT_MAX : $past(fault_count) + 8'h01); endproperty
  property p_hold; !fault_push && !clr |=> $stable(fault_count); endproperty
  property p_clear; clr && !fault_push |=> s_ok ##0 fault_count == 8'h00; endproperty
  property p_empty; rd_ent && fault_count == 8'h00 |=> od_rsp.ack && od_rsp.abort && od_rsp.abort_code == ABORT_EMPTY_HISTORY; endproperty
  property p_rdcnt; rd_cnt |=> s_ok ##0 od_rsp.rdata == {24'h0, $past(fault_count)}; endproperty
  a_cat: assert property (p_cat) else $error("summary categories wrong");
  a_any: assert property (p_any) else $error("general flag wrong");
  a_max: assert property (p_max) else $error("count above eight");
  a_push: assert property (p_push) else $error("count after push wrong");
  a_hold: assert property (p_hold) else $error("count moved without cause");
  a_clear: assert property (p_clear) else $error("clear failed");
  a_empty: assert property (p_empty) else $error("empty read not refused");
  a_rdcnt: assert property (p_rdcnt) else $error("count read wrong");
endmodule
bind fault_register_bank fault_monitor mon (.ref_clk(ref_clk), .nrst(nrst), .fault_cat(fault_cat),
  .fault_push(fault_push), .fault_report(fault_report), .od_req(od_req), .od_rsp(od_rsp),
  .fault_summary(fault_summary), .fault_count(fault_count), .unknown_number(unknown_number));

// ### tb/od_master.sv
`timescale 1ns/1ps
module od_master
  import fault_pkg::*;
(
  input wire logic ref_clk,
  output od_req_t od_req,
  input wire od_rsp_t od_rsp
);
  // ****************************************
  // Master access
  // ****************************************
  initial od_req = '0;
  // Idle fields are scrambled so no stale request can pass for a live one
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
    output od_rsp_t rsp);
    @(negedge ref_clk);
    od_req = '{valid: 1'b1, write: wr, index: idx, subindex: sub, wdata: wd};
    @(negedge ref_clk);
    rsp = od_rsp;
    od_req = {1'b0, ~od_req[56:0]};
  endtask
endmodule
